// >>> wdt_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block.
// Included by the watchdog design file; holds definitions only.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Byte addresses of the two registers on the APB slave.
`define WDT_OFS_CAUSE 12'h000
`define WDT_OFS_CTRL 12'h004

// Reset-cause register field positions.
`define WDT_CAUSE_WD 3
`define WDT_CAUSE_BO 2
`define WDT_CAUSE_EXT 1
`define WDT_CAUSE_PO 0

// Watchdog control register field positions.
`define WDT_CTRL_TIF 7
`define WDT_CTRL_TIE 6
`define WDT_CTRL_PSC3 5
`define WDT_CTRL_CHANGE_ENABLE 4
`define WDT_CTRL_WDE 3

// Reset values: power-on sets only the power-on cause flag.
`define WDT_CAUSE_RST 4'h1
`define WDT_PSC_RST 4'h0

// Change-enable window in system clock cycles.
`define WDT_CHG_WINDOW 3'h4

// Highest valid prescaler code; codes above it are reserved.
`define WDT_PSC_MAX 4'h9

// Shortest time-out in oscillator cycles and the nominal oscillator rate.
`define WDT_BASE_CYCLES 2048
`define WDT_OSC_HZ 128000

`endif

// >>> wdt_pkg.sv
// Types shared by the watchdog block.
// Assumes nothing of its surroundings.
package wdt_pkg;

	// Action taken on time-out.
	typedef enum logic [1:0] {
		WDT_STOPPED,
		WDT_IRQ,
		WDT_RST,
		WDT_IRQ_RST
	} wdt_mode_e;

	// Stored fields of the watchdog control register.
	typedef struct packed {
		logic tif;
		logic tie;
		logic change_enable;
		logic system_reset_enable;
		logic [3:0] psc;
	} wdt_ctrl_s;

	// Reset-cause flags.
	typedef struct packed {
		logic wd;
		logic bo;
		logic ext;
		logic po;
	} wdt_cause_s;

endpackage

// >>> wdt_top.sv
// Watchdog timer with reset-cause flags, reached over an APB slave.
// Assumes arst_n_i is the power-on reset, core strobes are on clk_sys_i, and wdt_osc_i is a free slow clock.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps

`include "wdt_regs.svh"

module wdt_top #(
	parameter int unsigned BASE_CYCLES = `WDT_BASE_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic wdt_osc_i,
	input wire logic always_on_fuse_i,
	input wire logic global_irq_en_i,
	input wire logic restart_i,
	input wire logic vector_ack_i,
	input wire logic brownout_reset_i,
	input wire logic external_reset_i,
	output logic irq_o,
	output logic sys_reset_o
);

	logic osc_meta_ff;
	logic osc_sync_ff;
	logic osc_prev_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic irq_ff;
	logic sys_reset_ff;
	logic [20:0] cnt_ff;
	logic [2:0] chg_cnt_ff;
	wdt_pkg::wdt_ctrl_s ctrl_ff;
	wdt_pkg::wdt_cause_s cause_ff;
	wdt_pkg::wdt_ctrl_s nxt_ctrl;
	wdt_pkg::wdt_cause_s nxt_cause;
	wdt_pkg::wdt_mode_e mode;
	logic [2:0] nxt_chg_cnt;
	logic [20:0] nxt_cnt;

	// Oscillator edge: only the second sync stage and its delayed copy are looked at.
	wire osc_tick = osc_sync_ff & ~osc_prev_ff;

	// APB decode; a write takes effect in the access cycle that sees pready high.
	wire apb_acc = psel_i & penable_i;
	wire apb_done = apb_acc & pready_ff;
	wire hit_cause = (paddr_i == `WDT_OFS_CAUSE);
	wire hit_ctrl = (paddr_i == `WDT_OFS_CTRL);
	wire wr_cause = apb_done & pwrite_i & hit_cause;
	wire wr_ctrl = apb_done & pwrite_i & hit_ctrl;
	wire nxt_pready = apb_acc & ~pready_ff;

	// Effective enables as software reads them; tie_rd also gates the interrupt request.
	wire fuse_prog = ~always_on_fuse_i;
	wire wde_rd = ctrl_ff.system_reset_enable | cause_ff.wd | fuse_prog;
	wire tie_rd = ctrl_ff.tie & ~fuse_prog;

	// Read images of both registers.
	wire [7:0] cause_rd = {4'h0, cause_ff};
	wire [7:0] ctrl_rd = {ctrl_ff.tif, tie_rd, ctrl_ff.psc[3], ctrl_ff.change_enable, wde_rd, ctrl_ff.psc[2:0]};
	wire [7:0] rd_sel = hit_cause ? cause_rd : (hit_ctrl ? ctrl_rd : 8'h00);

	// Time-out limit; reserved codes fall back to the longest period.
	wire [3:0] psc_eff = (ctrl_ff.psc > `WDT_PSC_MAX) ? `WDT_PSC_MAX : ctrl_ff.psc;
	wire [20:0] limit = 21'(BASE_CYCLES) << psc_eff;

	// Mode selection from the fuse and the two enables.
	always_comb begin
		if (fuse_prog) begin
			mode = wdt_pkg::WDT_RST;
		end else begin
			case ({ctrl_ff.system_reset_enable | cause_ff.wd, ctrl_ff.tie})
				2'b01: mode = wdt_pkg::WDT_IRQ;
				2'b10: mode = wdt_pkg::WDT_RST;
				2'b11: mode = wdt_pkg::WDT_IRQ_RST;
				default: mode = wdt_pkg::WDT_STOPPED;
			endcase
		end
	end

	// A count already past a shortened limit expires on the next oscillator edge.
	wire running = (mode != wdt_pkg::WDT_STOPPED);
	// A restart in the same cycle as the expiring edge wins, so a timely restart never fires.
	wire timeout = running & osc_tick & ~restart_i & (cnt_ff >= limit - 21'h1);
	wire irq_mode = (mode == wdt_pkg::WDT_IRQ);
	wire comb_mode = (mode == wdt_pkg::WDT_IRQ_RST);
	wire irq_set = timeout & (irq_mode | (comb_mode & ~ctrl_ff.tif));
	wire rst_fire = timeout & ((mode == wdt_pkg::WDT_RST) | (comb_mode & ctrl_ff.tif));
	wire sys_evt = sys_reset_ff | brownout_reset_i | external_reset_i;
	wire irq_cond = ctrl_ff.tif & tie_rd & global_irq_en_i;

	// Counter restarts on the restart strobe, any system reset, or while stopped.
	always_comb begin
		nxt_cnt = cnt_ff;
		if (restart_i | sys_evt | ~running) begin
			nxt_cnt = 21'h0;
		end else if (osc_tick) begin
			nxt_cnt = timeout ? 21'h0 : cnt_ff + 21'h1;
		end
	end

	// Reset-cause flags: hardware set wins over a software clear in the same cycle.
	always_comb begin
		nxt_cause = cause_ff;
		if (wr_cause) begin
			nxt_cause.wd = cause_ff.wd & pwdata_i[`WDT_CAUSE_WD];
			nxt_cause.bo = cause_ff.bo & pwdata_i[`WDT_CAUSE_BO];
			nxt_cause.ext = cause_ff.ext & pwdata_i[`WDT_CAUSE_EXT];
			nxt_cause.po = cause_ff.po & pwdata_i[`WDT_CAUSE_PO];
		end
		if (sys_reset_ff) begin
			nxt_cause.wd = 1'b1;
		end
		if (brownout_reset_i) begin
			nxt_cause.bo = 1'b1;
		end
		if (external_reset_i) begin
			nxt_cause.ext = 1'b1;
		end
	end

	// Control register update, timed sequence and hardware clearing.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_chg_cnt = chg_cnt_ff;
		if (chg_cnt_ff != 3'h0) begin
			nxt_chg_cnt = chg_cnt_ff - 3'h1;
		end
		if (chg_cnt_ff == 3'h1) begin
			nxt_ctrl.change_enable = 1'b0;
		end
		if (wr_ctrl) begin
			if (pwdata_i[`WDT_CTRL_TIF]) begin
				nxt_ctrl.tif = 1'b0;
			end
			nxt_ctrl.tie = pwdata_i[`WDT_CTRL_TIE];
			nxt_ctrl.change_enable = pwdata_i[`WDT_CTRL_CHANGE_ENABLE];
			nxt_chg_cnt = pwdata_i[`WDT_CTRL_CHANGE_ENABLE] ? `WDT_CHG_WINDOW : 3'h0;
			if (pwdata_i[`WDT_CTRL_WDE]) begin
				nxt_ctrl.system_reset_enable = 1'b1;
			end else if (ctrl_ff.change_enable) begin
				nxt_ctrl.system_reset_enable = 1'b0;
			end
			if (ctrl_ff.change_enable) begin
				nxt_ctrl.psc = {pwdata_i[`WDT_CTRL_PSC3], pwdata_i[2:0]};
			end
		end
		if (vector_ack_i) begin
			nxt_ctrl.tif = 1'b0;
			if (comb_mode) begin
				nxt_ctrl.tie = 1'b0;
			end
		end
		if (irq_set) begin
			nxt_ctrl.tif = 1'b1;
		end
		if (sys_evt) begin
			nxt_ctrl = '{tif: 1'b0, tie: 1'b0, change_enable: 1'b0, system_reset_enable: 1'b0, psc: `WDT_PSC_RST};
			nxt_chg_cnt = 3'h0;
		end
	end

	// Oscillator synchroniser.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_meta_ff <= 1'b0;
			osc_sync_ff <= 1'b0;
			osc_prev_ff <= 1'b0;
		end else begin
			osc_meta_ff <= wdt_osc_i;
			osc_sync_ff <= osc_meta_ff;
			osc_prev_ff <= osc_sync_ff;
		end
	end

	// APB answer: one wait state, read data and error latched on the same edge that raises pready.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= nxt_pready;
			if (nxt_pready) begin
				pslverr_ff <= ~(hit_cause | hit_ctrl);
				prdata_ff <= pwrite_i ? 32'h0 : {24'h0, rd_sel};
			end
		end
	end

	// Watchdog state; power-on leaves only the power-on flag set.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= 21'h0;
			chg_cnt_ff <= 3'h0;
			ctrl_ff <= '{tif: 1'b0, tie: 1'b0, change_enable: 1'b0, system_reset_enable: 1'b0, psc: `WDT_PSC_RST};
			cause_ff <= `WDT_CAUSE_RST;
			irq_ff <= 1'b0;
			sys_reset_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			chg_cnt_ff <= nxt_chg_cnt;
			ctrl_ff <= nxt_ctrl;
			cause_ff <= nxt_cause;
			irq_ff <= irq_cond;
			sys_reset_ff <= rst_fire;
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign irq_o = irq_ff;
	assign sys_reset_o = sys_reset_ff;

	// Checks on cause flags.
	a_cause_wd_set:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) sys_reset_o |=> cause_ff.wd)
		else $error("watchdog cause flag not set after watchdog reset");

	a_cause_bo_set:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) brownout_reset_i |=> cause_ff.bo)
		else $error("brown-out cause flag not set");

	a_cause_ext_set:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) external_reset_i |=> cause_ff.ext)
		else $error("external cause flag not set");

	a_cause_po_hold:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) cause_ff.po && !wr_cause |=> cause_ff.po)
		else $error("power-on flag lost without a write");

	a_rsvd_read_zero:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		apb_done && !pwrite_i && hit_cause |-> prdata_o[31:4] == 28'h0)
		else $error("reserved cause bits read non-zero");

	// Checks on the timed change sequence and on the reset enable read forced by the watchdog cause flag.
	a_change_enable_four_cycles:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_ctrl && pwdata_i[`WDT_CTRL_CHANGE_ENABLE] && !sys_evt) ##1 (!wr_ctrl && !sys_evt)[*4] |=> !ctrl_ff.change_enable)
		else $error("change enable did not clear after four cycles");

	a_wde_clear_locked:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		wr_ctrl && !pwdata_i[`WDT_CTRL_WDE] && !ctrl_ff.change_enable && ctrl_ff.system_reset_enable && !sys_evt |=> ctrl_ff.system_reset_enable)
		else $error("reset enable cleared without change enable");

	a_psc_locked:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		wr_ctrl && !ctrl_ff.change_enable && !sys_evt |=> $stable(ctrl_ff.psc))
		else $error("prescaler changed without change enable");

	a_wde_forced:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		apb_done && !pwrite_i && hit_ctrl && $past(cause_ff.wd, 2) && cause_ff.wd |-> prdata_o[`WDT_CTRL_WDE])
		else $error("reset enable read clear while watchdog cause flag set");

	// Checks on time-out actions and the interrupt request.
	a_irq_gate:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		irq_o |-> $past(ctrl_ff.tif) && $past(ctrl_ff.tie) && $past(global_irq_en_i))
		else $error("interrupt requested without flag and enables");

	a_vector_clears:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		vector_ack_i && !irq_set |=> !ctrl_ff.tif ##1 !irq_o)
		else $error("vector execution did not clear the interrupt flag");

	a_combined_ack:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		vector_ack_i && comb_mode && !sys_evt |=> !ctrl_ff.tie)
		else $error("combined mode vector did not clear interrupt enable");

	a_second_timeout:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		timeout && comb_mode && ctrl_ff.tif |=> sys_reset_o ##1 !sys_reset_o)
		else $error("second combined time-out gave no system reset");

	a_fuse_reset:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		timeout && fuse_prog |=> sys_reset_o && !ctrl_ff.tif)
		else $error("programmed fuse time-out gave no reset");

	a_reset_pulse:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(sys_reset_o) |=> !sys_reset_o)
		else $error("system reset pulse longer than one cycle");

	a_restart_zero:
	assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) restart_i |=> cnt_ff == 21'h0 && !sys_reset_o)
		else $error("restart did not clear the counter");

endmodule

// >>> wdt_core_model.sv
// Model of the processor core side: the slow watchdog oscillator and the vector acknowledge.
// Assumes the bench drives restart and the global interrupt enable itself.
`timescale 1ns/1ps

module wdt_core_model (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic irq_i,
	input wire logic ack_en_i,
	output logic osc_o,
	output logic vector_ack_o
);
	logic [2:0] hold;

	// Free-running slow oscillator of about 128 kHz, unrelated to the system clock.
	initial begin
		osc_o = 1'b0;
		forever #3906 osc_o = ~osc_o;
	end

	// Executes the vector once per request, then waits out the lag of the request line.
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vector_ack_o <= 1'b0;
			hold <= 3'h0;
		end else begin
			vector_ack_o <= irq_i && ack_en_i && !vector_ack_o && hold == 3'h0;
			hold <= vector_ack_o ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
		end
	end
endmodule

// >>> watchdog_timer_reset_flags_bench.sv
// Self-checking bench of the watchdog with reset-cause flags, driven over APB.
// Assumes wdt_top from the design files and the core model beside it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module watchdog_timer_reset_flags_bench;
	localparam logic [11:0] CS = 12'h000;
	localparam logic [11:0] CT = 12'h004;
	logic clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, fuse = 1, glb = 0, kick = 0, bo = 0, ext = 0, ack_en = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, irq, sysr, osc, ack, e, ok;
	int err_count = 0, total_checks = 0, nrst = 0, n0, t, k;

	// Clock and a count of system reset pulses.
	initial forever #25 clk = ~clk;
	always @(posedge clk) if (sysr === 1'b1) nrst++;

	wdt_top #(.BASE_CYCLES(4)) i_dut (.clk_sys_i(clk), .arst_n_i(arst_n), .paddr_i(paddr), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .wdt_osc_i(osc), .always_on_fuse_i(fuse), .global_irq_en_i(glb),
		.restart_i(kick), .vector_ack_i(ack), .brownout_reset_i(bo), .external_reset_i(ext),
		.irq_o(irq), .sys_reset_o(sysr));
	wdt_core_model i_core (.clk_sys_i(clk), .arst_n_i(arst_n), .irq_i(irq), .ack_en_i(ack_en),
		.osc_o(osc), .vector_ack_o(ack));

	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// One APB transfer; rel releases the bus and lets one edge pass, otherwise the next may follow at once.
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic rel);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			$display("[ERR] pready exp 1 got %b", pready);
		end
		rd = prdata;
		e = pslverr;
		if (rel) begin
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask

	// Reads a register and compares its low byte.
	task rchk(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00, 1'b1);
		`CHK((a == CS) ? "cause" : "ctrl", x, rd[7:0])
	endtask

	// Waits for the interrupt request or the system reset pulse under a bound.
	task wt(input logic s_irq);
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (((s_irq ? irq : sysr) !== 1'b1) && t < 3000);
		`CHK("wait", 1'b1, t < 3000)
	endtask

	task pwr_on;
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask

	// Gives up if the sequence hangs.
	initial begin
		#4000000;
		err_count++;
		results();
	end

	// Main sequence of scenarios.
	initial begin
		pwr_on();
		rchk(CS, 8'h01);
		rchk(CT, 8'h00);
		apb(1'b0, 12'h008, 8'h00, 1'b1);
		`CHK("slverr", 1'b1, e)
		apb(1'b1, CS, 8'hFF, 1'b1);
		rchk(CS, 8'h01);
		bo <= 1'b1;
		@(posedge clk);
		bo <= 1'b0;
		@(posedge clk);
		rchk(CS, 8'h05);
		ext <= 1'b1;
		@(posedge clk);
		ext <= 1'b0;
		@(posedge clk);
		rchk(CS, 8'h07);
		apb(1'b1, CS, 8'h00, 1'b1);
		rchk(CS, 8'h00);
		// Timed change sequence: refusals, acceptance and the window's end.
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		apb(1'b1, CT, 8'h08, 1'b1);
		apb(1'b1, CT, 8'h00, 1'b1);
		rchk(CT, 8'h08);
		apb(1'b1, CT, 8'h09, 1'b1);
		rchk(CT, 8'h08);
		apb(1'b1, CT, 8'h18, 1'b0);
		apb(1'b1, CT, 8'h09, 1'b1);
		rchk(CT, 8'h09);
		apb(1'b1, CT, 8'h18, 1'b1);
		rchk(CT, 8'h19);
		rchk(CT, 8'h09);
		apb(1'b1, CT, 8'h18, 1'b1);
		repeat (2) @(posedge clk);
		apb(1'b1, CT, 8'h00, 1'b1);
		rchk(CT, 8'h09);
		apb(1'b1, CT, 8'h18, 1'b0);
		apb(1'b1, CT, 8'h00, 1'b1);
		rchk(CT, 8'h00);
		// Interrupt mode with prescaler codes 0 to 2.
		glb <= 1'b1;
		for (k = 0; k < 3; k++) begin
			kick <= 1'b1;
			@(posedge clk);
			kick <= 1'b0;
			apb(1'b1, CT, 8'h18, 1'b0);
			apb(1'b1, CT, 8'h40 | k[7:0], 1'b1);
			wt(1'b1);
			ok = (t + 7 > (4 << k) * 156 - 160) && (t + 7 < (4 << k) * 157 + 170);
			`CHK("period", 1'b1, ok)
			rchk(CT, 8'hC0 | k[7:0]);
			glb <= 1'b0;
			repeat (3) @(posedge clk);
			`CHK("irq", 1'b0, irq)
			glb <= 1'b1;
			repeat (3) @(posedge clk);
			`CHK("irq", 1'b1, irq)
			apb(1'b1, CT, 8'h80 | k[7:0], 1'b1);
			rchk(CT, k[7:0]);
		end
		// Reset mode kept alive by restarts, then let it expire.
		apb(1'b1, CT, 8'h18, 1'b0);
		apb(1'b1, CT, 8'h08, 1'b1);
		n0 = nrst;
		repeat (8) begin
			kick <= 1'b1;
			@(posedge clk);
			kick <= 1'b0;
			repeat (300) @(posedge clk);
		end
		`CHK("resets", n0, nrst)
		wt(1'b0);
		@(posedge clk);
		`CHK("sysreset", 1'b0, sysr)
		rchk(CS, 8'h08);
		rchk(CT, 8'h08);
		// Combined mode: unserviced interrupt, then serviced one.
		apb(1'b1, CS, 8'h00, 1'b1);
		apb(1'b1, CT, 8'h48, 1'b1);
		wt(1'b1);
		wt(1'b0);
		rchk(CS, 8'h08);
		apb(1'b1, CS, 8'h00, 1'b1);
		ack_en <= 1'b1;
		apb(1'b1, CT, 8'h48, 1'b1);
		wt(1'b1);
		repeat (10) @(posedge clk);
		rchk(CT, 8'h08);
		wt(1'b0);
		ack_en <= 1'b0;
		apb(1'b1, CT, 8'h18, 1'b0);
		apb(1'b1, CT, 8'h00, 1'b1);
		rchk(CT, 8'h08);
		apb(1'b1, CS, 8'h00, 1'b1);
		rchk(CT, 8'h00);
		// Programmed fuse after a fresh power-on.
		fuse <= 1'b0;
		pwr_on();
		rchk(CS, 8'h01);
		rchk(CT, 8'h08);
		apb(1'b1, CT, 8'h40, 1'b1);
		rchk(CT, 8'h08);
		wt(1'b0);
		`CHK("irq", 1'b0, irq)
		results();
	end
endmodule
